// [clksel_consts.svh]
`ifndef CLKSEL_CONSTS_SVH
`define CLKSEL_CONSTS_SVH
// Register byte addresses on APB
`define ADDR_OSC_CTRL      12'h000
`define ADDR_CLK_DIV       12'h004
// Source encodings
`define SRC_FRC            3'h0
`define SRC_FRC_PLL        3'h1
`define SRC_PRI            3'h2
`define SRC_PRI_PLL        3'h3
`define SRC_SEC            3'h4
`define SRC_LOW_POWER_INTERNAL_RC           3'h5
`define SRC_RSVD           3'h6
`define SRC_FRC_DIV        3'h7
// Primary submodes
`define SUB_EC             2'h0
`define SUB_XT             2'h1
`define SUB_HS             2'h2
`define SUB_INTERNAL       2'h3
// Field positions
`define CUR_HI             14
`define CUR_LO             12
`define NEW_HI             10
`define NEW_LO             8
`define LOCK_SEL_BIT       7
`define PLL_LOCK_BIT       5
`define FAIL_BIT           3
`define SEC_EN_BIT         1
`define SWITCH_BIT         0
`define ROI_BIT            15
`define DOZE_HI            14
`define DOZE_LO            12
`define DOZE_EN_BIT        11
`define FAST_RC_POSTSCALER_FIELD_HI           10
`define FAST_RC_POSTSCALER_FIELD_LO           8
// Reset values and unlock keys
`define FAST_RC_POSTSCALER_FIELD_RESET        3'h1
`define KEY_HI_A           8'h78
`define KEY_HI_B           8'h9A
`define KEY_LO_A           8'h46
`define KEY_LO_B           8'h57
// Timing: ten new-source cycles before switch
`define SETTLE_CYCLES      4'hA
`define OST_CYCLES         10'h3FF
// Edges after reset release before the synchronised straps are trusted
`define POR_SETTLE_EDGES   2'h2
`endif

// [clksel_pkg.sv]
package clksel_pkg;
   typedef enum logic [2:0] {
      SRC_FRC_E, SRC_FRC_PLL_E, SRC_PRI_E, SRC_PRI_PLL_E,
      SRC_SEC_E, SRC_LOW_POWER_INTERNAL_RC_E, SRC_RSVD_E, SRC_FRC_DIV_E
   } source_t;
   typedef struct packed {
      logic       recover_on_interrupt;
      logic [2:0] doze_ratio;
      logic       doze_enable_bit;
      logic [2:0] fast_rc_postscaler_field;
   } clock_divider_control_t;
   typedef enum {SW_IDLE, SW_START, SW_SETTLE} sw_state_t;
endpackage

// [system_clock_select_and_divider.sv]
`timescale 1ns/1ps
`include "clksel_consts.svh"
module system_clock_select_and_divider (
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [1:0]  i_primary_submode_cfg,
   input  wire logic [2:0]  i_initial_source_cfg,
   input  wire logic [1:0]  i_switch_monitor_cfg,
   input  wire logic        i_osc_pin_function_cfg,
   input  wire logic        i_wdt_enable,
   input  wire logic        i_interrupt,
   input  wire logic        i_pll_locked,
   input  wire logic        i_start_up_timer_done,
   input  wire logic        i_new_source_tick,
   input  wire logic        i_clock_failure,
   output logic      [2:0]  o_current_source,
   output logic      [1:0]  o_primary_submode,
   output logic             o_pll_enable,
   output logic             o_primary_osc_on,
   output logic             o_secondary_osc_on,
   output logic             o_fast_rc_on,
   output logic             o_low_power_rc_on,
   output logic      [2:0]  o_fast_rc_postscaler,
   output logic      [2:0]  o_doze_ratio,
   output logic             o_fail_safe_monitor_en,
   output logic             o_primary_osc_out_pin_cycle_clk
);

   // Configuration pins sampled through two flops
   logic [8:0] cfg_meta;
   logic [8:0] cfg_sync;
   logic       int_meta;
   logic       int_sync;
   logic [3:0] ev_meta;
   logic [3:0] ev_sync;
   logic [3:0] ev_q;
   logic       por_done;
   logic [1:0] por_cnt;
   logic [2:0] cur_src;
   logic [2:0] new_src;
   logic [1:0] submode;
   logic       sel_lock;
   logic       pll_lock;
   logic       fail_flag;
   logic       sec_en;
   logic       switch_req;
   clksel_pkg::clock_divider_control_t clock_divider_control;
   clksel_pkg::sw_state_t sw_state;
   logic [3:0] settle_cnt;
   logic [1:0] key_hi;
   logic [1:0] key_lo;
   logic       sw_enable;
   logic       mon_enable;
   logic       wr_access;
   logic       wr_osc;
   logic       wr_div;
   logic       hi_open;
   logic       lo_open;
   logic       src_uses_pll;
   logic       ready_ok;
   logic       instr_clk;
   logic       ev_rise;
   logic       cfg_locked;

   // Synchronise straps and asynchronous events
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cfg_meta <= 9'h000;
         cfg_sync <= 9'h000;
         int_meta <= 1'b0;
         int_sync <= 1'b0;
      end else begin
         cfg_meta <= {i_osc_pin_function_cfg, i_wdt_enable, i_switch_monitor_cfg, i_primary_submode_cfg,
                      i_initial_source_cfg};
         cfg_sync <= cfg_meta;
         int_meta <= i_interrupt;
         int_sync <= int_meta;
      end
   end

   // Oscillator status pins; bit order lock, timer, tick, failure
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ev_meta <= 4'h0;
         ev_sync <= 4'h0;
         ev_q    <= 4'h0;
      end else begin
         ev_meta <= {i_pll_locked, i_start_up_timer_done, i_new_source_tick, i_clock_failure};
         ev_sync <= ev_meta;
         ev_q    <= ev_sync;
      end
   end

   assign ev_rise    = ev_sync[1] & ~ev_q[1];
   // Straps are not trusted until they have passed both flops
   assign sw_enable  = por_done & ~cfg_sync[6];
   assign mon_enable = por_done & (cfg_sync[6:5] == 2'h0);
   assign cfg_locked = sel_lock & mon_enable;
   assign src_uses_pll = (new_src == `SRC_FRC_PLL) || (new_src == `SRC_PRI_PLL);

   // APB decode; zero-wait slave
   assign PREADY    = 1'b1;
   assign PSLVERR   = PSEL & PENABLE & (PADDR != `ADDR_OSC_CTRL) & (PADDR != `ADDR_CLK_DIV);
   assign wr_access = PSEL & PENABLE & PWRITE;
   assign wr_osc    = wr_access & (PADDR == `ADDR_OSC_CTRL);
   assign wr_div    = wr_access & (PADDR == `ADDR_CLK_DIV);
   assign hi_open   = (key_hi == 2'h2);
   assign lo_open   = (key_lo == 2'h2);

   // Unlock key tracking per byte; any other byte write breaks the chain, except a low-byte-only write keeps an open high key
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         key_hi <= 2'h0;
         key_lo <= 2'h0;
      end else if (wr_access) begin
         if (wr_osc && PSTRB[1] && key_hi == 2'h0 && PWDATA[15:8] == `KEY_HI_A) begin
            key_hi <= 2'h1;
         end else if (wr_osc && PSTRB[1] && key_hi == 2'h1 && PWDATA[15:8] == `KEY_HI_B) begin
            key_hi <= 2'h2;
         end else if (!(wr_osc && PSTRB[0] && !PSTRB[1] && key_hi == 2'h2)) begin
            key_hi <= 2'h0;
         end else begin
            key_hi <= 2'h2;
         end
         if (wr_osc && PSTRB[0] && key_lo == 2'h0 && PWDATA[7:0] == `KEY_LO_A) begin
            key_lo <= 2'h1;
         end else if (wr_osc && PSTRB[0] && key_lo == 2'h1 && PWDATA[7:0] == `KEY_LO_B) begin
            key_lo <= 2'h2;
         end else begin
            key_lo <= 2'h0;
         end
      end
   end

   // Power-on selection loaded once the straps have crossed both sync flops
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         por_done <= 1'b0;
         por_cnt  <= 2'h0;
      end else if (!por_done) begin
         if (por_cnt == `POR_SETTLE_EDGES) begin
            por_done <= 1'b1;
         end else begin
            por_cnt <= por_cnt + 2'h1;
         end
      end
   end

   // Oscillator control: source fields and switch machine
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cur_src    <= `SRC_FRC_DIV;
         new_src    <= `SRC_FRC_DIV;
         submode    <= `SUB_INTERNAL;
         switch_req <= 1'b0;
         sw_state   <= clksel_pkg::SW_IDLE;
         settle_cnt <= 4'h0;
      end else if (!por_done) begin
         cur_src  <= cfg_sync[2:0];
         new_src  <= cfg_sync[2:0];
         submode  <= cfg_sync[4:3];
         sw_state <= clksel_pkg::SW_IDLE;
      end else begin
         if (wr_osc && PSTRB[1] && hi_open && !(cfg_locked) && sw_state == clksel_pkg::SW_IDLE) begin
            new_src <= PWDATA[`NEW_HI:`NEW_LO];
         end
         case (sw_state)
            clksel_pkg::SW_IDLE: begin
               if (!sw_enable) begin
                  switch_req <= 1'b0;
               end else if (wr_osc && PSTRB[0] && lo_open && PWDATA[`SWITCH_BIT] && !cfg_locked) begin
                  if (new_src == cur_src || new_src == `SRC_RSVD) begin
                     switch_req <= 1'b0;
                  end else begin
                     switch_req <= 1'b1;
                     sw_state   <= clksel_pkg::SW_START;
                  end
               end
            end
            clksel_pkg::SW_START: begin
               settle_cnt <= 4'h0;
               if (ready_ok) begin
                  sw_state <= clksel_pkg::SW_SETTLE;
               end
            end
            clksel_pkg::SW_SETTLE: begin
               if (ev_rise) begin
                  if (settle_cnt == `SETTLE_CYCLES - 4'h1) begin
                     cur_src    <= new_src;
                     switch_req <= 1'b0;
                     sw_state   <= clksel_pkg::SW_IDLE;
                  end else begin
                     settle_cnt <= settle_cnt + 4'h1;
                  end
               end
            end
            default: sw_state <= clksel_pkg::SW_IDLE;
         endcase
      end
   end

   // New source ready: crystal timer and PLL lock where needed
   assign ready_ok = (!(new_src == `SRC_PRI || new_src == `SRC_PRI_PLL) || submode == `SUB_EC
                      || ev_sync[2]) && (!src_uses_pll || ev_sync[3]);

   // Status flags: lock set-only, PLL lock, fail set wins over clear
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sel_lock  <= 1'b0;
         pll_lock  <= 1'b0;
         fail_flag <= 1'b0;
         sec_en    <= 1'b0;
      end else begin
         if (wr_osc && PSTRB[0] && lo_open) begin
            if (PWDATA[`LOCK_SEL_BIT]) begin
               sel_lock <= 1'b1;
            end
            sec_en <= PWDATA[`SEC_EN_BIT];
         end
         if (sw_state == clksel_pkg::SW_IDLE && switch_req == 1'b0 && wr_osc && lo_open
             && PWDATA[`SWITCH_BIT] && new_src != cur_src && sw_enable && !cfg_locked) begin
            pll_lock <= 1'b0;
         end else if (!((cur_src == `SRC_FRC_PLL || cur_src == `SRC_PRI_PLL) || src_uses_pll)) begin
            pll_lock <= 1'b0;
         end else begin
            pll_lock <= ev_sync[3] | ev_sync[2];
         end
         if (mon_enable && ev_sync[0]) begin
            fail_flag <= 1'b1;
         end else if (sw_state == clksel_pkg::SW_START) begin
            fail_flag <= 1'b0;
         end else if (wr_osc && PSTRB[0] && lo_open && !PWDATA[`FAIL_BIT]) begin
            fail_flag <= 1'b0;
         end
      end
   end

   // Divider register; interrupt recovery wins over a software write
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         clock_divider_control <= '{1'b0, 3'h0, 1'b0, `FAST_RC_POSTSCALER_FIELD_RESET};
      end else begin
         if (wr_div && PSTRB[1]) begin
            clock_divider_control <= PWDATA[15:8];
         end
         if (clock_divider_control.recover_on_interrupt && int_sync) begin
            clock_divider_control.doze_enable_bit <= 1'b0;
         end
      end
   end

   // Instruction clock: processor clock halved
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         instr_clk <= 1'b0;
      end else begin
         instr_clk <= ~instr_clk;
      end
   end

   // Oscillator enables and outputs, registered
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         o_current_source     <= `SRC_FRC_DIV;
         o_primary_submode    <= `SUB_INTERNAL;
         o_pll_enable         <= 1'b0;
         o_primary_osc_on     <= 1'b0;
         o_secondary_osc_on   <= 1'b0;
         o_fast_rc_on         <= 1'b1;
         o_low_power_rc_on    <= 1'b0;
         o_fast_rc_postscaler <= `FAST_RC_POSTSCALER_FIELD_RESET;
         o_doze_ratio         <= 3'h0;
         o_fail_safe_monitor_en <= 1'b0;
         o_primary_osc_out_pin_cycle_clk <= 1'b0;
      end else begin
         o_current_source  <= cur_src;
         o_primary_submode <= submode;
         o_pll_enable <= (cur_src == `SRC_FRC_PLL) || (cur_src == `SRC_PRI_PLL)
                         || (switch_req && src_uses_pll);
         o_primary_osc_on <= (cur_src == `SRC_PRI) || (cur_src == `SRC_PRI_PLL)
                             || (switch_req && (new_src == `SRC_PRI || new_src == `SRC_PRI_PLL));
         o_secondary_osc_on <= (cur_src == `SRC_SEC) || sec_en
                               || (switch_req && new_src == `SRC_SEC);
         o_fast_rc_on <= (cur_src == `SRC_FRC) || (cur_src == `SRC_FRC_PLL) || (cur_src == `SRC_FRC_DIV)
                         || (switch_req && (new_src == `SRC_FRC || new_src == `SRC_FRC_PLL
                         || new_src == `SRC_FRC_DIV));
         o_low_power_rc_on <= (cur_src == `SRC_LOW_POWER_INTERNAL_RC) || cfg_sync[7] || mon_enable
                              || (switch_req && new_src == `SRC_LOW_POWER_INTERNAL_RC);
         o_fast_rc_postscaler <= (cur_src == `SRC_FRC) ? 3'h0 : clock_divider_control.fast_rc_postscaler_field;
         o_doze_ratio <= clock_divider_control.doze_enable_bit ? clock_divider_control.doze_ratio : 3'h0;
         o_fail_safe_monitor_en <= mon_enable;
         o_primary_osc_out_pin_cycle_clk <= instr_clk & ~cfg_sync[8]
                                            & (submode != `SUB_XT) & (submode != `SUB_HS);
      end
   end

   // Read data; unimplemented bits return zero
   always_comb begin
      PRDATA = 32'h0000_0000;
      if (PADDR == `ADDR_OSC_CTRL) begin
         PRDATA[`CUR_HI:`CUR_LO] = cur_src;
         PRDATA[`NEW_HI:`NEW_LO] = new_src;
         PRDATA[`LOCK_SEL_BIT]   = sel_lock;
         PRDATA[`PLL_LOCK_BIT]   = pll_lock;
         PRDATA[`FAIL_BIT]       = fail_flag;
         PRDATA[`SEC_EN_BIT]     = sec_en;
         PRDATA[`SWITCH_BIT]     = switch_req;
      end else if (PADDR == `ADDR_CLK_DIV) begin
         PRDATA[15:8] = clock_divider_control;
      end
   end

endmodule

// [clksel_asserts.sv]
`timescale 1ns/1ps
// Port-level checks on the clock select block
module clksel_asserts (
   input wire logic        I_REF_CLK,
   input wire logic        I_RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [1:0]  i_switch_monitor_cfg,
   input wire logic [2:0]  o_current_source,
   input wire logic        o_pll_enable,
   input wire logic [2:0]  o_fast_rc_postscaler,
   input wire logic [2:0]  o_doze_ratio,
   input wire logic        o_fail_safe_monitor_en,
   input wire logic        o_primary_osc_out_pin_cycle_clk
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   // Access phase of a read, per register
   wire rd0 = PSEL && PENABLE && !PWRITE && PADDR == 12'h000;
   wire rd4 = PSEL && PENABLE && !PWRITE && PADDR == 12'h004;

   zero_wait_a: assert property (PSEL && PENABLE |-> PREADY) else $error("slave did not answer");
   bad_addr_a: assert property (PSEL && PENABLE |-> PSLVERR == !(PADDR inside {12'h000, 12'h004}))
      else $error("error response wrong");
   osc_unused_a: assert property (rd0 |-> PRDATA[31:15] == 17'h0 && {PRDATA[11], PRDATA[6], PRDATA[4], PRDATA[2]} == 4'h0)
      else $error("unused control bit not zero");
   div_unused_a: assert property (rd4 |-> PRDATA[31:16] == 16'h0 && PRDATA[7:0] == 8'h00)
      else $error("unused divider bit not zero");
   cur_field_a: assert property (rd0 |=> o_current_source == $past(PRDATA[14:12]))
      else $error("current source field differs from output");
   doze_apply_a: assert property (rd4 |=> o_doze_ratio == ($past(PRDATA[11]) ? $past(PRDATA[14:12]) : 3'h0))
      else $error("doze ratio output wrong");
   post_scale_a: assert property (o_current_source == 3'h0 |-> o_fast_rc_postscaler == 3'h0)
      else $error("postscaler active on plain fast rc");
   pll_run_a: assert property (o_current_source inside {3'h1, 3'h3} |-> o_pll_enable)
      else $error("pll source without pll");
   no_reserved_a: assert property (o_current_source != 3'h6)
      else $error("reserved source running");
   monitor_en_a: assert property (o_fail_safe_monitor_en |-> i_switch_monitor_cfg == 2'b00)
      else $error("monitor enabled by wrong setting");
   cycle_clk_a: assert property (o_primary_osc_out_pin_cycle_clk |=> !o_primary_osc_out_pin_cycle_clk)
      else $error("cycle clock not halved");
   // Main scenarios reached
   cover property ($changed(o_current_source));
   cover property (o_doze_ratio == 3'h7);
   cover property (PSEL && PENABLE && PSLVERR);
endmodule

bind system_clock_select_and_divider clksel_asserts u_chk (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .i_switch_monitor_cfg(i_switch_monitor_cfg), .o_current_source(o_current_source), .o_pll_enable(o_pll_enable),
   .o_fast_rc_postscaler(o_fast_rc_postscaler), .o_doze_ratio(o_doze_ratio),
   .o_fail_safe_monitor_en(o_fail_safe_monitor_en),
   .o_primary_osc_out_pin_cycle_clk(o_primary_osc_out_pin_cycle_clk));

// [tb.sv]
`timescale 1ns/1ps
module tb;
   logic        I_REF_CLK = 1'b0;
   logic        I_RST_N = 1'b0;
   logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
   logic [3:0]  PSTRB = 4'h0;
   logic        PREADY, PSLVERR, serr;
   logic        wdt = 1'b0, irq = 1'b0, pll_ok = 1'b0, tick = 1'b0, fail = 1'b0;
   logic [2:0]  cur, post, doze;
   logic [1:0]  sub, smc = 2'b00;
   logic        pll_en, pri_on, sec_on, frc_on, low_power_internal_rc_on, fsm_en, cyc;
   int          num_errors = 0, compares = 0;

   system_clock_select_and_divider uut (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .i_primary_submode_cfg(2'b00), .i_initial_source_cfg(3'h7), .i_switch_monitor_cfg(smc),
      .i_osc_pin_function_cfg(1'b0), .i_wdt_enable(wdt), .i_interrupt(irq), .i_pll_locked(pll_ok),
      .i_start_up_timer_done(pll_ok), .i_new_source_tick(tick), .i_clock_failure(fail), .o_current_source(cur),
      .o_primary_submode(sub), .o_pll_enable(pll_en), .o_primary_osc_on(pri_on), .o_secondary_osc_on(sec_on),
      .o_fast_rc_on(frc_on), .o_low_power_rc_on(low_power_internal_rc_on), .o_fast_rc_postscaler(post), .o_doze_ratio(doze),
      .o_fail_safe_monitor_en(fsm_en), .o_primary_osc_out_pin_cycle_clk(cyc));

   always #25 I_REF_CLK = ~I_REF_CLK;
   // New source clock stand-in: a rising edge every second cycle
   always @(posedge I_REF_CLK) tick <= ~tick;

   task automatic stop_test;
      if (num_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; two idle edges after it so registered outputs have settled when the caller looks
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= d; PSTRB <= s;
      @(posedge I_REF_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge I_REF_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) begin
         num_errors++;
         stop_test;
      end
      rdat = PRDATA;
      serr = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
      repeat (2) @(posedge I_REF_CLK);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rdat, exp);
   endtask

   task automatic unlock_lo;
      apb(1'b1, 12'h000, 32'h0000_0046, 4'h1);
      apb(1'b1, 12'h000, 32'h0000_0057, 4'h1);
   endtask

   // Full software switch sequence: both unlocks, new source, request
   task automatic switch_to(input logic [2:0] s);
      apb(1'b1, 12'h000, 32'h0000_7800, 4'h2);
      apb(1'b1, 12'h000, 32'h0000_9A00, 4'h2);
      apb(1'b1, 12'h000, {21'h0, s, 8'h00}, 4'h2);
      unlock_lo;
      apb(1'b1, 12'h000, 32'h0000_0001, 4'h1);
   endtask

   // Poll the request bit until hardware drops it, bounded
   task automatic wait_sw(input int lim);
      for (int i = 0; i < lim; i++) begin
         apb(1'b0, 12'h000, 32'h0, 4'h0);
         if (rdat[0] === 1'b0) return;
      end
      num_errors++;
      stop_test;
   endtask

   initial begin
      repeat (10) @(posedge I_REF_CLK);
      I_RST_N <= 1'b1;
      repeat (5) @(posedge I_REF_CLK);
      rdchk(12'h000, 32'h0000_7700);
      rdchk(12'h004, 32'h0000_0100);
      chk(post, 3'h1);
      chk(sub, 2'b00);
      apb(1'b0, 12'h008, 32'h0, 4'h0);
      chk(serr, 1'b1);
      // Half an unlock must not open the high byte
      apb(1'b1, 12'h000, 32'h0000_7800, 4'h2);
      apb(1'b1, 12'h000, 32'h0000_0000, 4'h2);
      rdchk(12'h000, 32'h0000_7700);
      apb(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hF);
      rdchk(12'h004, 32'h0000_FF00);
      chk(post, 3'h7);
      irq <= 1'b1;
      @(posedge I_REF_CLK);
      irq <= 1'b0;
      repeat (4) @(posedge I_REF_CLK);
      rdchk(12'h004, 32'h0000_F700);
      chk(doze, 3'h0);
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, 12'h004, 32'h0000_0900 | (k << 12), 4'hF);
         chk(doze, k[2:0]);
      end
      irq <= 1'b1;
      @(posedge I_REF_CLK);
      irq <= 1'b0;
      repeat (4) @(posedge I_REF_CLK);
      chk(doze, 3'h7);
      apb(1'b1, 12'h004, 32'h0000_0100, 4'hF);
      chk(doze, 3'h0);
      switch_to(3'h0);
      rdchk(12'h000, 32'h0000_7001);
      wait_sw(40);
      rdchk(12'h000, 32'h0000_0000);
      chk(post, 3'h0);
      // PLL not yet locked: the switch must stay pending
      switch_to(3'h3);
      repeat (40) @(posedge I_REF_CLK);
      rdchk(12'h000, 32'h0000_0301);
      pll_ok <= 1'b1;
      wait_sw(40);
      rdchk(12'h000, 32'h0000_3320);
      chk({pll_en, pri_on, frc_on}, 3'b110);
      switch_to(3'h3);
      wait_sw(3);
      rdchk(12'h000, 32'h0000_3320);
      fail <= 1'b1;
      repeat (4) @(posedge I_REF_CLK);
      fail <= 1'b0;
      repeat (4) @(posedge I_REF_CLK);
      rdchk(12'h000, 32'h0000_3328);
      apb(1'b1, 12'h000, 32'h0000_0000, 4'h1);
      rdchk(12'h000, 32'h0000_3328);
      unlock_lo;
      apb(1'b1, 12'h000, 32'h0000_0002, 4'h1);
      rdchk(12'h000, 32'h0000_3322);
      chk(sec_on, 1'b1);
      wdt <= 1'b1;
      repeat (5) @(posedge I_REF_CLK);
      chk(low_power_internal_rc_on, 1'b1);
      unlock_lo;
      apb(1'b1, 12'h000, 32'h0000_0082, 4'h1);
      switch_to(3'h0);
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      chk(rdat & 32'h0000_7F01, 32'h0000_3300);
      // Second reset with switching and monitor disabled by strap
      smc <= 2'b10;
      I_RST_N <= 1'b0;
      repeat (10) @(posedge I_REF_CLK);
      I_RST_N <= 1'b1;
      repeat (5) @(posedge I_REF_CLK);
      chk(fsm_en, 1'b0);
      chk(low_power_internal_rc_on, 1'b1);
      switch_to(3'h0);
      rdchk(12'h000, 32'h0000_7000);
      stop_test;
   end
endmodule
